// ===== inc/htcp_pkg.sv
package htcp_pkg;
    // Two-wire framing and command codes
    localparam logic [6:0] TGT_ADDR = 7'h38;
    localparam logic [7:0] CMD_INIT = 8'hbe;
    localparam logic [7:0] CMD_TRIG = 8'hac;
    localparam logic [7:0] CMD_SRST = 8'hba;
    localparam logic [7:0] CMD_STAT = 8'h71;
    localparam logic [7:0] INIT_ARG0 = 8'h08;
    localparam logic [7:0] INIT_ARG1 = 8'h00;
    localparam logic [7:0] TRIG_ARG0 = 8'h33;
    localparam logic [7:0] TRIG_ARG1 = 8'h00;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [1:0] WR_ARG_LAST = 2'h2;
    localparam logic [1:0] WR_DONE = 2'h3;
    // Status byte layout
    localparam int STAT_BUSY_BIT = 7;
    localparam int STAT_CAL_BIT = 3;
    localparam logic [7:0] STAT_RSVD_MASK = 8'h77;
    // Read stream: status, five sample bytes, check byte, then filler
    localparam logic [2:0] RD_CRC_IDX = 3'h6;
    localparam logic [2:0] RD_LAST_IDX = 3'h7;
    localparam logic [7:0] RD_FILL = 8'hff;
    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_SEED = 8'hff;
    // Timing, in milliseconds and the core clock in kHz
    localparam int CLK_KHZ = 200000;
    localparam int BOOT_MS = 20;
    localparam int INIT_MS = 10;
    localparam int MEAS_MS = 80;
    localparam int SRST_MS = 20;
    localparam int CNT_W = 25;
    typedef enum logic [1:0] {EV_NONE, EV_INIT, EV_TRIG, EV_SRST} htcp_ev_t;
    typedef enum logic [2:0] {S_BOOT, S_IDLE, S_INIT, S_MEAS, S_SRST} htcp_state_t;
    typedef enum logic [1:0] {L_IDLE, L_ADDR, L_WR, L_RD} htcp_link_t;
endpackage : htcp_pkg

// ===== design/htcp_sync.sv
module htcp_sync
    import htcp_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic en_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    // Two-stage synchroniser; only the second stage is visible
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else if (en_in) begin
            meta_reg <= d_in;
            q_reg <= meta_reg;
        end
    end

    assign q_out = q_reg;
endmodule : htcp_sync

// ===== design/htcp_crc_step.sv
module htcp_crc_step
    import htcp_pkg::*;
(
    input wire logic [7:0] crc_in,
    input wire logic [7:0] data_in,
    output logic [7:0] crc_out
);
    // One byte through the check polynomial, msb first
    always_comb begin
        logic [7:0] c;
        c = crc_in ^ data_in;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
        end
        crc_out = c;
    end
endmodule : htcp_crc_step

// ===== design/htcp_sensor_port.sv
module htcp_sensor_port
    import htcp_pkg::*;
#(
    parameter int unsigned BOOT_CYC = BOOT_MS * CLK_KHZ,
    parameter int unsigned INIT_CYC = INIT_MS * CLK_KHZ,
    parameter int unsigned MEAS_CYC = MEAS_MS * CLK_KHZ,
    parameter int unsigned SRST_CYC = SRST_MS * CLK_KHZ,
    parameter logic CAL_STORED = 1'b1
) (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic CE_IN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic [19:0] HUM_SAMPLE_IN,
    input wire logic [19:0] TEMP_SAMPLE_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    output logic [7:0] STATUS_OUT
);
    // Core domain state
    htcp_state_t state_reg;
    htcp_state_t state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic ready_reg;
    logic cal_reg;
    logic [19:0] hum_reg;
    logic [19:0] temp_reg;
    logic [7:0] status_reg;
    logic ev_last_reg;
    logic ev_s;
    logic ev_seen_w;
    logic done_w;
    logic busy_w;
    logic [7:0] status_w;
    logic [7:0] crc_chain [0:6];
    logic [7:0] rd_tab [0:7];

    // Link domain state
    htcp_link_t phase_reg;
    logic start_tog_reg;
    logic stop_tog_reg;
    logic start_seen_reg;
    logic stop_seen_reg;
    logic [3:0] bitn_reg;
    logic [6:0] sh_reg;
    logic ack_pend_reg;
    logic rd_dir_reg;
    logic [1:0] widx_reg;
    logic [7:0] cmd_reg;
    logic [7:0] arg0_reg;
    logic [2:0] ptr_reg;
    logic ev_tog_reg;
    htcp_ev_t ev_code_reg;
    logic sda_drv_reg;
    logic [2:0] flags_s;
    logic rdy_s;
    logic busy_s;
    logic cal_s;

    // Command events cross by toggle; the code is stable before the toggle lands
    htcp_sync #(.W(1)) u_ev_sync (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .en_in(CE_IN),
        .d_in(ev_tog_reg),
        .q_out(ev_s)
    );

    assign ev_seen_w = ev_s ^ ev_last_reg;
    assign done_w = (cnt_reg == '0);
    assign busy_w = (state_reg == S_INIT) || (state_reg == S_MEAS);
    // Reserved bits stay zero by construction
    assign status_w = ({7'h00, busy_w} << STAT_BUSY_BIT) | ({7'h00, cal_reg} << STAT_CAL_BIT);

    // Next state: soft reset wins outside boot, other commands only taken while idle
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg - CNT_W'(1);
        if (ev_seen_w && ev_code_reg == EV_SRST && state_reg != S_BOOT) begin
            state_next = S_SRST;
            cnt_next = CNT_W'(SRST_CYC - 1);
        end else begin
            case (state_reg)
                S_BOOT: begin
                    if (done_w) begin
                        state_next = S_IDLE;
                    end
                end
                S_IDLE: begin
                    cnt_next = cnt_reg;
                    if (ev_seen_w && ev_code_reg == EV_INIT) begin
                        state_next = S_INIT;
                        cnt_next = CNT_W'(INIT_CYC - 1);
                    end else if (ev_seen_w && ev_code_reg == EV_TRIG) begin
                        state_next = S_MEAS;
                        cnt_next = CNT_W'(MEAS_CYC - 1);
                    end
                end
                S_INIT, S_MEAS, S_SRST: begin
                    if (done_w) begin
                        state_next = S_IDLE;
                    end
                end
                default: begin
                    state_next = S_IDLE;
                end
            endcase
        end
    end

    // Sequencer registers, frozen while the clock enable is low
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_reg <= S_BOOT;
            cnt_reg <= CNT_W'(BOOT_CYC - 1);
            ev_last_reg <= 1'b0;
        end else if (CE_IN) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            ev_last_reg <= ev_s;
        end
    end

    // Readiness and calibration flags
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ready_reg <= 1'b0;
            cal_reg <= 1'b0;
        end else if (CE_IN) begin
            if (state_next == S_SRST) begin
                ready_reg <= 1'b0;
                cal_reg <= 1'b0;
            end else if ((state_reg == S_BOOT || state_reg == S_SRST) && done_w) begin
                ready_reg <= 1'b1;
                cal_reg <= CAL_STORED;
            end else if (state_reg == S_INIT && done_w) begin
                cal_reg <= 1'b1;
            end
        end
    end

    // Samples change only while busy, so the link may read them when busy is low
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            hum_reg <= '0;
            temp_reg <= '0;
            status_reg <= '0;
        end else if (CE_IN) begin
            status_reg <= status_w;
            if (state_reg == S_MEAS && done_w && state_next == S_IDLE) begin
                hum_reg <= HUM_SAMPLE_IN;
                temp_reg <= TEMP_SAMPLE_IN;
            end
        end
    end

    assign STATUS_OUT = status_reg;

    // Read stream table; slot 0 uses the link-side copy of the status
    assign rd_tab[0] = ({7'h00, busy_s} << STAT_BUSY_BIT) | ({7'h00, cal_s} << STAT_CAL_BIT);
    assign rd_tab[1] = hum_reg[19:12];
    assign rd_tab[2] = hum_reg[11:4];
    assign rd_tab[3] = {hum_reg[3:0], temp_reg[19:16]};
    assign rd_tab[4] = temp_reg[15:8];
    assign rd_tab[5] = temp_reg[7:0];
    assign rd_tab[6] = crc_chain[6];
    assign rd_tab[7] = RD_FILL;
    assign crc_chain[0] = CRC_SEED;

    // Check byte over the status and the five sample bytes
    generate
        for (genvar g = 0; g < 6; g++) begin : g_crc
            htcp_crc_step u_step (
                .crc_in(crc_chain[g]),
                .data_in(g == 0 ? status_w : rd_tab[g]),
                .crc_out(crc_chain[g+1])
            );
        end
    endgenerate

    // Core flags into the link domain
    htcp_sync #(.W(3)) u_flag_sync (
        .clk_in(SCL_IN),
        .rst_in(RST_IN),
        .en_in(1'b1),
        .d_in({ready_reg, busy_w, cal_reg}),
        .q_out(flags_s)
    );

    assign rdy_s = flags_s[2];
    assign busy_s = flags_s[1];
    assign cal_s = flags_s[0];

    // Start and stop caught on the data edges while the clock is high
    always_ff @(negedge SDA_IN or posedge RST_IN) begin
        if (RST_IN) begin
            start_tog_reg <= 1'b0;
        end else if (SCL_IN) begin
            start_tog_reg <= ~start_tog_reg;
        end
    end

    always_ff @(posedge SDA_IN or posedge RST_IN) begin
        if (RST_IN) begin
            stop_tog_reg <= 1'b0;
        end else if (SCL_IN) begin
            stop_tog_reg <= ~stop_tog_reg;
        end
    end

    // The toggles settle a half clock before the next rising edge, so the
    // rising-edge logic reads them without a synchroniser
    logic new_frame_w;
    logic stopped_w;
    logic [7:0] byte_in_w;
    logic last_bit_w;
    logic ack_slot_w;
    logic addr_hit_w;
    logic wr_byte_w;
    logic init_ok_w;
    logic trig_ok_w;
    logic srst_w;
    logic ev_fire_w;
    htcp_ev_t ev_kind_w;
    htcp_link_t phase_after_ack_w;
    logic [7:0] rd_byte_w;
    logic tx_bit_w;
    logic sda_drv_next;

    assign new_frame_w = start_tog_reg ^ start_seen_reg;
    assign stopped_w = stop_tog_reg ^ stop_seen_reg;
    assign byte_in_w = {sh_reg, SDA_IN};
    assign last_bit_w = (bitn_reg == BIT_LAST) && !new_frame_w;
    assign ack_slot_w = (bitn_reg == ACK_SLOT) && !new_frame_w;
    assign addr_hit_w = (byte_in_w[7:1] == TGT_ADDR) && rdy_s;
    assign wr_byte_w = (phase_reg == L_WR) && last_bit_w;
    assign srst_w = (widx_reg == 2'h0) && (byte_in_w == CMD_SRST);
    assign init_ok_w = (widx_reg == WR_ARG_LAST) && (cmd_reg == CMD_INIT)
        && (arg0_reg == INIT_ARG0) && (byte_in_w == INIT_ARG1);
    assign trig_ok_w = (widx_reg == WR_ARG_LAST) && (cmd_reg == CMD_TRIG)
        && (arg0_reg == TRIG_ARG0) && (byte_in_w == TRIG_ARG1);
    assign ev_fire_w = wr_byte_w && (srst_w || init_ok_w || trig_ok_w);
    assign ev_kind_w = srst_w ? EV_SRST : (init_ok_w ? EV_INIT : EV_TRIG);
    assign phase_after_ack_w = (phase_reg == L_ADDR)
        ? (ack_pend_reg ? (rd_dir_reg ? L_RD : L_WR) : L_IDLE)
        : ((phase_reg == L_RD && SDA_IN) ? L_IDLE : phase_reg);
    assign rd_byte_w = rd_tab[ptr_reg];
    assign tx_bit_w = rd_byte_w[~bitn_reg[2:0]];
    // Ack in the ninth slot, otherwise read data pulled low for zeros
    assign sda_drv_next = (bitn_reg == ACK_SLOT)
        ? (ack_pend_reg && (phase_reg == L_ADDR || phase_reg == L_WR))
        : ((phase_reg == L_RD) && !tx_bit_w);

    // Bit counter, shifter and transfer phase
    always_ff @(posedge SCL_IN or posedge RST_IN) begin
        if (RST_IN) begin
            start_seen_reg <= 1'b0;
            stop_seen_reg <= 1'b0;
            phase_reg <= L_IDLE;
            bitn_reg <= '0;
            sh_reg <= '0;
        end else if (new_frame_w) begin
            start_seen_reg <= start_tog_reg;
            stop_seen_reg <= stop_tog_reg;
            phase_reg <= L_ADDR;
            bitn_reg <= 4'h1;
            sh_reg <= {6'h00, SDA_IN};
        end else if (ack_slot_w) begin
            bitn_reg <= '0;
            phase_reg <= phase_after_ack_w;
        end else if (phase_reg != L_IDLE) begin
            bitn_reg <= bitn_reg + 4'h1;
            sh_reg <= byte_in_w[6:0];
        end
    end

    // Address match and acknowledge decision at the eighth bit
    always_ff @(posedge SCL_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ack_pend_reg <= 1'b0;
            rd_dir_reg <= 1'b0;
        end else if (new_frame_w) begin
            ack_pend_reg <= 1'b0;
        end else if (last_bit_w && phase_reg == L_ADDR) begin
            ack_pend_reg <= addr_hit_w;
            rd_dir_reg <= byte_in_w[0];
        end else if (last_bit_w) begin
            ack_pend_reg <= (phase_reg == L_WR);
        end
    end

    // Command byte and first argument; the second argument completes initialise and trigger, soft reset needs only the command byte
    always_ff @(posedge SCL_IN or posedge RST_IN) begin
        if (RST_IN) begin
            widx_reg <= '0;
            cmd_reg <= '0;
            arg0_reg <= '0;
        end else if (new_frame_w) begin
            widx_reg <= '0;
        end else if (wr_byte_w && widx_reg != WR_DONE) begin
            widx_reg <= widx_reg + 2'h1;
            cmd_reg <= (widx_reg == 2'h0) ? byte_in_w : cmd_reg;
            arg0_reg <= (widx_reg == 2'h1) ? byte_in_w : arg0_reg;
        end
    end

    // Read pointer: every read and every status request starts at the status byte
    always_ff @(posedge SCL_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ptr_reg <= '0;
        end else if (ack_slot_w && phase_reg == L_ADDR && rd_dir_reg) begin
            ptr_reg <= '0;
        end else if (wr_byte_w && widx_reg == 2'h0 && byte_in_w == CMD_STAT) begin
            ptr_reg <= '0;
        end else if (ack_slot_w && phase_reg == L_RD && !SDA_IN && ptr_reg != RD_LAST_IDX) begin
            ptr_reg <= ptr_reg + 3'h1;
        end
    end

    // Command event toward the core
    always_ff @(posedge SCL_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ev_tog_reg <= 1'b0;
            ev_code_reg <= EV_NONE;
        end else if (ev_fire_w) begin
            ev_tog_reg <= ~ev_tog_reg;
            ev_code_reg <= ev_kind_w;
        end
    end

    // Data changes only after a falling clock edge, as the host expects
    always_ff @(negedge SCL_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sda_drv_reg <= 1'b0;
        end else begin
            sda_drv_reg <= sda_drv_next;
        end
    end

    // Open drain: only ever pulls low, and lets go as soon as a stop is seen
    assign SDA_OUT = 1'b0;
    assign SDA_OE_OUT = sda_drv_reg && !stopped_w;

    property p_boot_ready;
        @(posedge CLK_IN) disable iff (RST_IN)
        (state_reg == S_BOOT || state_reg == S_SRST) |-> !ready_reg;
    endproperty
    a_boot_ready: assert property (p_boot_ready) else $error("ready while booting");

    property p_no_ack_unready;
        @(posedge SCL_IN) disable iff (RST_IN)
        (phase_reg == L_ADDR && last_bit_w && !rdy_s) |=> !ack_pend_reg;
    endproperty
    a_no_ack_unready: assert property (p_no_ack_unready) else $error("ack before ready");

    property p_addr_ack;
        @(posedge SCL_IN) disable iff (RST_IN)
        (phase_reg == L_ADDR && last_bit_w && rdy_s && byte_in_w[7:1] == TGT_ADDR)
        |=> ack_pend_reg ##1 (phase_reg == L_RD || phase_reg == L_WR || new_frame_w);
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not taken");

    property p_wr_ack;
        @(posedge SCL_IN) disable iff (RST_IN)
        (phase_reg == L_WR && ack_slot_w && ack_pend_reg && !stopped_w) |-> SDA_OE_OUT;
    endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("write byte not acked");

    property p_trig;
        @(posedge CLK_IN) disable iff (RST_IN)
        (CE_IN && state_reg == S_IDLE && ev_seen_w && ev_code_reg == EV_TRIG)
        |=> (state_reg == S_MEAS && status_reg == $past(status_reg)) ##1 status_reg[STAT_BUSY_BIT];
    endproperty
    a_trig: assert property (p_trig) else $error("trigger did not start");

    property p_srst;
        @(posedge CLK_IN) disable iff (RST_IN)
        (CE_IN && ev_seen_w && ev_code_reg == EV_SRST && state_reg != S_BOOT)
        |=> (state_reg == S_SRST && !cal_reg && !ready_reg);
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset not taken");

    property p_meas_end;
        @(posedge CLK_IN) disable iff (RST_IN)
        (CE_IN && state_reg == S_MEAS && done_w && !(ev_seen_w && ev_code_reg == EV_SRST))
        |=> (!status_w[STAT_BUSY_BIT] && hum_reg == $past(HUM_SAMPLE_IN));
    endproperty
    a_meas_end: assert property (p_meas_end) else $error("busy after measurement");

    property p_cal;
        @(posedge CLK_IN) disable iff (RST_IN)
        (CE_IN && state_reg == S_INIT && done_w && !(ev_seen_w && ev_code_reg == EV_SRST))
        |=> status_w[STAT_CAL_BIT];
    endproperty
    a_cal: assert property (p_cal) else $error("calibration flag not set");

    property p_nack_end;
        @(posedge SCL_IN) disable iff (RST_IN)
        (phase_reg == L_RD && ack_slot_w && SDA_IN) |=> (phase_reg == L_IDLE || new_frame_w);
    endproperty
    a_nack_end: assert property (p_nack_end) else $error("read kept after nack");

    property p_rsvd;
        @(posedge SCL_IN) disable iff (RST_IN)
        (phase_reg == L_RD) |-> ((rd_tab[0] & STAT_RSVD_MASK) == 8'h00);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");

    property p_freeze;
        @(posedge CLK_IN) disable iff (RST_IN)
        !CE_IN |=> ($stable(state_reg) && $stable(cnt_reg));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");
endmodule : htcp_sensor_port

// ===== dv/htcp_host.sv
module htcp_host (
    input wire logic sens_oe_in,
    output logic scl_out,
    output logic sda_out
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int T_Q = 12; // Quarter of the 48 ns link period
    logic drv_low;
    // Open-drain data wire, pulled up when nobody pulls it low
    assign sda_out = !(drv_low || sens_oe_in);
    // Clock rests high outside frames
    initial begin
        scl_out = 1'b1;
        drv_low = 1'b0;
    end
    // Start: data falls while the clock is high
    task automatic start_bit;
        drv_low = 1'b0;
        #T_Q scl_out = 1'b1;
        #T_Q drv_low = 1'b1;
        #T_Q scl_out = 1'b0;
    endtask : start_bit
    // Stop: data rises while the clock is high
    task automatic stop_bit;
        drv_low = 1'b1;
        #T_Q scl_out = 1'b1;
        #T_Q drv_low = 1'b0;
        #T_Q;
    endtask : stop_bit
    // One bit: data moves only while the clock is low, sampled mid-high
    task automatic bit_io(input logic b, output logic s);
        drv_low = !b;
        #T_Q scl_out = 1'b1;
        #T_Q s = sda_out;
        #T_Q scl_out = 1'b0;
        #T_Q;
    endtask : bit_io
    // Byte out msb first, ninth bit released for the acknowledge
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask : wr_byte
    // Byte in, then acknowledge or refuse the next one
    task automatic rd_byte(output logic [7:0] b, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(nack, s);
    endtask : rd_byte
    // Two idle clocks with data high so the link sees readiness
    task automatic idle_clk;
        logic s;
        bit_io(1'b1, s);
        bit_io(1'b1, s);
        scl_out = 1'b1;
    endtask : idle_clk
endmodule : htcp_host

// ===== dv/htcp_sensor_port_tb.sv
module htcp_sensor_port_tb
    import htcp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned BOOT_N = 400;
    localparam int unsigned INIT_N = 100;
    localparam int unsigned MEAS_N = 100;
    localparam int unsigned SRST_N = 400;
    localparam int LIMIT = 20000; // Whole sequence needs well under this
    logic clk = 1'b0;
    logic rst = 1'b0; // Raised after time zero so its edge also resets the bus-clock flops
    logic ce = 1'b1;
    logic sda_val;
    logic scl;
    logic sda;
    logic oe;
    logic [19:0] hum = 20'h0;
    logic [19:0] temp = 20'h0;
    logic [7:0] status;
    logic [7:0] exp_stat = 8'h00; // Model of {busy,000,cal,000}
    logic [7:0] exp_q[$];
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    integer seed = 77883;

    htcp_sensor_port #(.BOOT_CYC(BOOT_N), .INIT_CYC(INIT_N), .MEAS_CYC(MEAS_N),
        .SRST_CYC(SRST_N), .CAL_STORED(1'b0)) uut (
        .CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .SCL_IN(scl), .SDA_IN(sda),
        .HUM_SAMPLE_IN(hum), .TEMP_SAMPLE_IN(temp), .SDA_OUT(sda_val), .SDA_OE_OUT(oe),
        .STATUS_OUT(status));
    htcp_host host (.sens_oe_in(oe), .scl_out(scl), .sda_out(sda));

    // Core clock, 200 MHz
    initial begin
        forever #2.5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fail_count++;
            results();
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    // Check byte over the stream, msb first
    function automatic logic [7:0] crc8(input logic [7:0] q[$]);
        logic [7:0] c;
        c = CRC_SEED;
        foreach (q[i]) begin
            c ^= q[i];
            for (int k = 0; k < 8; k++) c = c[7] ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
        end
        return c;
    endfunction : crc8

    // Write frame; stops early once a byte is refused
    task automatic wr(input logic [7:0] q[$], input logic exp_ack);
        logic ack;
        host.start_bit();
        foreach (q[i]) begin
            host.wr_byte(q[i], ack);
            check("write ack", {7'h0, ack}, {7'h0, exp_ack});
            if (!ack) break;
        end
        host.stop_bit();
    endtask : wr

    // Read frame, refusing the last byte
    task automatic rd(input logic [7:0] e[$]);
        logic ack;
        logic [7:0] b;
        host.start_bit();
        host.wr_byte({TGT_ADDR, 1'b1}, ack);
        check("read addr ack", {7'h0, ack}, 8'h01);
        foreach (e[i]) begin
            host.rd_byte(b, i == e.size() - 1);
            check("read byte", b, e[i]);
        end
        host.stop_bit();
    endtask : rd

    task automatic stat;
        @(posedge clk);
        #1;
        check("status port", status, exp_stat);
    endtask : stat

    // Bounded wait for the busy flag to clear
    task automatic wait_busy;
        int n;
        n = 0;
        while (status[STAT_BUSY_BIT] !== 1'b0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_busy

    // Main sequence
    initial begin
        #1 rst = 1'b1;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        stat();
        wr('{8'h70}, 1'b0);
        repeat (BOOT_N) @(posedge clk);
        host.idle_clk();
        wr('{8'h70, CMD_STAT}, 1'b1);
        rd('{exp_stat});
        check("data level", {7'h00, sda_val}, 8'h00);
        wr('{8'h72}, 1'b0);
        // Initialise sets the calibrated flag
        wr('{8'h70, CMD_INIT, INIT_ARG0, INIT_ARG1}, 1'b1);
        exp_stat = 8'h80;
        stat();
        // Clock enable low must hold the initialise past its own length
        ce = 1'b0;
        repeat (INIT_N + 50) @(posedge clk);
        stat();
        ce = 1'b1;
        wait_busy();
        exp_stat = 8'h08;
        stat();
        // Measurement with random samples held steady
        @(posedge clk);
        #1;
        hum = 20'($random(seed));
        temp = 20'($random(seed));
        wr('{8'h70, CMD_TRIG, TRIG_ARG0, TRIG_ARG1}, 1'b1);
        exp_stat = 8'h88;
        stat();
        wait_busy();
        exp_stat = 8'h08;
        stat();
        exp_q = '{exp_stat, hum[19:12], hum[11:4], {hum[3:0], temp[19:16]}, temp[15:8],
            temp[7:0]};
        exp_q.push_back(crc8(exp_q));
        exp_q.push_back(RD_FILL);
        rd(exp_q);
        rd('{8'h08});
        // Trigger with wrong arguments is ignored
        wr('{8'h70, CMD_TRIG, 8'h00, 8'h00}, 1'b1);
        stat();
        // Soft reset drops calibration and readiness for a while
        wr('{8'h70, CMD_SRST}, 1'b1);
        exp_stat = 8'h00;
        stat();
        wr('{8'h70}, 1'b0);
        repeat (SRST_N) @(posedge clk);
        host.idle_clk();
        rd('{8'h00});
        results();
    end
endmodule : htcp_sensor_port_tb
